// [logic/gpio_exp_map.svh]
// register map, reset values and slave address of the i2c gpio expander
// assumes: included by the expander module and the testbench
`ifndef GPIO_EXP_MAP_SVH
`define GPIO_EXP_MAP_SVH
`define ADDR_BASE 4'h4
`define CMD_IN0 8'h00
`define CMD_IN1 8'h01
`define CMD_OUT0 8'h02
`define CMD_OUT1 8'h03
`define CMD_POL0 8'h04
`define CMD_POL1 8'h05
`define CMD_CFG0 8'h06
`define CMD_CFG1 8'h07
`define CMD_DRV0A 8'h40
`define CMD_DRV0B 8'h41
`define CMD_DRV1A 8'h42
`define CMD_DRV1B 8'h43
`define CMD_LAT0 8'h44
`define CMD_LAT1 8'h45
`define CMD_PEN0 8'h46
`define CMD_PEN1 8'h47
`define CMD_PSEL0 8'h48
`define CMD_PSEL1 8'h49
`define CMD_MSK0 8'h4a
`define CMD_MSK1 8'h4b
`define CMD_STS0 8'h4c
`define CMD_STS1 8'h4d
`define CMD_OCFG 8'h4f
`define RST_OUT 16'hffff
`define RST_POL 16'h0000
`define RST_CFG 16'hffff
`define RST_DRV 32'hffffffff
`define RST_LAT 16'h0000
`define RST_PEN 16'h0000
`define RST_PSEL 16'hffff
`define RST_MSK 16'hffff
`define RST_OCFG 8'h00
`define BYTE_BITS 4'h8
`endif

// [logic/gpio_exp_pkg.sv]
// types shared by the i2c gpio expander
// assumes: map header sits beside this file
package gpio_exp_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK, ST_WR, ST_WACK, ST_RD, ST_RACK
	} i2c_state_e;
	// per-port pin drive bundle
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe_n;
		logic [15:0] drive;
		logic [7:0] pull_en;
		logic [7:0] pull_up;
	} port_drv_s;
endpackage : gpio_exp_pkg

// [logic/i2c_gpio_expander_16bit.sv]
// i2c slave 16-bit gpio expander, two 8-bit ports, open-drain change alert
// assumes: scl, sda, straps and pins are asynchronous; pads resolve oe_n
//
// Summary of operation
// R1 - sixteen lines in two 8-bit ports, each usable as input or output
// R2 - input, output, polarity and direction register pairs, 8 bits per port
// R3 - every interrupt mask bit is set after reset
// R4 - alert asserts while an unmasked input differs from its input register value
// R5 - alert is active low open-drain, released otherwise
// R6 - reset loads all register defaults and the idle bus state
// R7 - three address pins set the low slave address bits
// R8 - after reset all lines are high-impedance inputs
// R9 - no glitches on the lines during reset and power-up
// R10 - push-pull or open-drain selected per whole 8-bit port
// R11 - read-only status register shows which input caused the alert
// R12 - four drive-strength levels programmed per output bit
// R13 - latched input change held until the input register is read
// R14 - pull enable per bit connects the internal resistor
// R15 - pull select per bit chooses pull-up or pull-down
// R16 - a set mask bit blocks that input from the alert
// R17 - pin n of each port maps to bit n of its register
// R18 - command byte after address becomes the register pointer
// R19 - last address bit: one reads, zero writes
// R20 - input registers follow pins regardless of direction; writes ignored
// R21 - output register reads return the written value, not the pins
// R22 - alert clears on input read, or when a non-latched input returns
// R23 - polarity bit inverts the input value reported
`timescale 1ns/10ps
`include "gpio_exp_map.svh"
module i2c_gpio_expander_16bit
	import gpio_exp_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic slave_addr_sel_bit0_i,
	input wire logic slave_addr_sel_bit1_i,
	input wire logic slave_addr_sel_bit2_i,
	input wire logic [7:0] port_a_line_i,
	input wire logic [7:0] port_b_line_i,
	output port_drv_s port_a_drv_o,
	output port_drv_s port_b_drv_o,
	output logic alert_o,
	output logic alert_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
logic [20:0] sync1_r;
logic [20:0] sync2_r;
logic scl_q_r;
logic sda_q_r;
wire logic [20:0] raw_in = {scl_i, sda_i, slave_addr_sel_bit2_i, slave_addr_sel_bit1_i,
	slave_addr_sel_bit0_i, port_b_line_i, port_a_line_i};

always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		sync1_r <= 21'h180000; // bus lines idle high
		sync2_r <= 21'h180000;
		scl_q_r <= 1'b1;
		sda_q_r <= 1'b1;
	end else begin
		sync1_r <= raw_in;
		sync2_r <= sync1_r;
		scl_q_r <= sync2_r[20];
		sda_q_r <= sync2_r[19];
	end
end

wire logic scl_s = sync2_r[20];
wire logic sda_s = sync2_r[19];
wire logic [2:0] addr_pins = sync2_r[18:16];
wire logic [15:0] pins = sync2_r[15:0]; // R17 R20
wire logic scl_rise = scl_s & ~scl_q_r;
wire logic scl_fall = ~scl_s & scl_q_r;
wire logic start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
wire logic stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;

////////////////////////////////////////////////////////////////////////////////
// registers
logic [15:0] out_r;
logic [15:0] pol_r;
logic [15:0] cfg_r;
logic [31:0] drv_r;
logic [15:0] lat_r;
logic [15:0] pen_r;
logic [15:0] psel_r;
logic [15:0] msk_r;
logic [7:0] ocfg_r;
logic [15:0] ref_r;
logic [15:0] lpend_r;
logic [15:0] lval_r;

////////////////////////////////////////////////////////////////////////////////
// i2c slave state
i2c_state_e state_r;
logic [3:0] cnt_r;
logic [7:0] sh_r;
logic [7:0] ptr_r;
logic rw_r;
logic sda_oe_n_r;

wire logic byte_done = (cnt_r == `BYTE_BITS);
wire logic addr_hit = (sh_r[7:1] == {`ADDR_BASE, addr_pins}); // R7
wire logic [7:0] ptr_next = {ptr_r[7:1], ~ptr_r[0]};
wire logic load_evt = scl_fall & ((state_r == ST_AACK & rw_r) | (state_r == ST_RACK));
wire logic wr_en = scl_fall & (state_r == ST_WR) & byte_done;
wire logic snap_a = load_evt & (ptr_r == `CMD_IN0);
wire logic snap_b = load_evt & (ptr_r == `CMD_IN1);
wire logic [15:0] snap_m = {{8{snap_b}}, {8{snap_a}}};

////////////////////////////////////////////////////////////////////////////////
// input value, latching and change detection
wire logic [15:0] in_val_now = pins ^ pol_r; // R23 R20
wire logic [15:0] diff = in_val_now ^ ref_r;
wire logic [15:0] lset = lat_r & diff & ~lpend_r; // R13
wire logic [15:0] in_rep = (lat_r & lpend_r & lval_r) | (~(lat_r & lpend_r) & in_val_now); // R13
wire logic [15:0] pend = (diff & ~lat_r) | lpend_r; // R22
wire logic [15:0] sts = pend & ~msk_r; // R11 R16 R4

always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		ref_r <= 16'h0000;
		lpend_r <= 16'h0000;
		lval_r <= 16'h0000;
	end else begin
		ref_r <= (ref_r & ~snap_m) | (in_val_now & snap_m); // R22
		lpend_r <= (lpend_r & ~snap_m) | (lset & ~snap_m); // R13
		lval_r <= (lval_r & ~lset) | (in_val_now & lset);
	end
end

////////////////////////////////////////////////////////////////////////////////
// read data select
function automatic logic [7:0] rd_sel(input logic [7:0] p);
	case (p)
		`CMD_IN0: rd_sel = in_rep[7:0];
		`CMD_IN1: rd_sel = in_rep[15:8];
		`CMD_OUT0: rd_sel = out_r[7:0]; // R21
		`CMD_OUT1: rd_sel = out_r[15:8];
		`CMD_POL0: rd_sel = pol_r[7:0];
		`CMD_POL1: rd_sel = pol_r[15:8];
		`CMD_CFG0: rd_sel = cfg_r[7:0];
		`CMD_CFG1: rd_sel = cfg_r[15:8];
		`CMD_DRV0A: rd_sel = drv_r[7:0];
		`CMD_DRV0B: rd_sel = drv_r[15:8];
		`CMD_DRV1A: rd_sel = drv_r[23:16];
		`CMD_DRV1B: rd_sel = drv_r[31:24];
		`CMD_LAT0: rd_sel = lat_r[7:0];
		`CMD_LAT1: rd_sel = lat_r[15:8];
		`CMD_PEN0: rd_sel = pen_r[7:0];
		`CMD_PEN1: rd_sel = pen_r[15:8];
		`CMD_PSEL0: rd_sel = psel_r[7:0];
		`CMD_PSEL1: rd_sel = psel_r[15:8];
		`CMD_MSK0: rd_sel = msk_r[7:0];
		`CMD_MSK1: rd_sel = msk_r[15:8];
		`CMD_STS0: rd_sel = sts[7:0]; // R11
		`CMD_STS1: rd_sel = sts[15:8];
		`CMD_OCFG: rd_sel = ocfg_r;
		default: rd_sel = 8'h00;
	endcase
endfunction : rd_sel

wire logic [7:0] rd_byte = rd_sel(ptr_r);

////////////////////////////////////////////////////////////////////////////////
// register writes; input and status pointers ignore writes
always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		out_r <= `RST_OUT; // R6
		pol_r <= `RST_POL;
		cfg_r <= `RST_CFG; // R8
		drv_r <= `RST_DRV;
		lat_r <= `RST_LAT;
		pen_r <= `RST_PEN;
		psel_r <= `RST_PSEL;
		msk_r <= `RST_MSK; // R3
		ocfg_r <= `RST_OCFG;
	end else if (wr_en) begin
		case (ptr_r) // R2 R20
			`CMD_OUT0: out_r[7:0] <= sh_r;
			`CMD_OUT1: out_r[15:8] <= sh_r;
			`CMD_POL0: pol_r[7:0] <= sh_r;
			`CMD_POL1: pol_r[15:8] <= sh_r;
			`CMD_CFG0: cfg_r[7:0] <= sh_r;
			`CMD_CFG1: cfg_r[15:8] <= sh_r;
			`CMD_DRV0A: drv_r[7:0] <= sh_r; // R12
			`CMD_DRV0B: drv_r[15:8] <= sh_r;
			`CMD_DRV1A: drv_r[23:16] <= sh_r;
			`CMD_DRV1B: drv_r[31:24] <= sh_r;
			`CMD_LAT0: lat_r[7:0] <= sh_r;
			`CMD_LAT1: lat_r[15:8] <= sh_r;
			`CMD_PEN0: pen_r[7:0] <= sh_r;
			`CMD_PEN1: pen_r[15:8] <= sh_r;
			`CMD_PSEL0: psel_r[7:0] <= sh_r;
			`CMD_PSEL1: psel_r[15:8] <= sh_r;
			`CMD_MSK0: msk_r[7:0] <= sh_r;
			`CMD_MSK1: msk_r[15:8] <= sh_r;
			`CMD_OCFG: ocfg_r <= sh_r;
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// i2c slave sequencer
always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		state_r <= ST_IDLE; // R6
		cnt_r <= 4'h0;
		sh_r <= 8'h00;
		ptr_r <= 8'h00;
		rw_r <= 1'b0;
		sda_oe_n_r <= 1'b1;
	end else if (stop_c) begin
		state_r <= ST_IDLE;
		sda_oe_n_r <= 1'b1;
	end else if (start_c) begin
		state_r <= ST_ADDR;
		cnt_r <= 4'h0;
		sda_oe_n_r <= 1'b1;
	end else begin
		case (state_r)
			ST_ADDR, ST_CMD, ST_WR: begin
				if (scl_rise) begin
					sh_r <= {sh_r[6:0], sda_s};
					cnt_r <= cnt_r + 4'h1;
				end else if (scl_fall && byte_done) begin
					cnt_r <= 4'h0;
					sda_oe_n_r <= 1'b0;
					if (state_r == ST_ADDR) begin
						rw_r <= sh_r[0]; // R19
						state_r <= addr_hit ? ST_AACK : ST_IDLE;
						sda_oe_n_r <= ~addr_hit;
					end else if (state_r == ST_CMD) begin
						ptr_r <= sh_r; // R18
						state_r <= ST_CACK;
					end else begin
						ptr_r <= ptr_next;
						state_r <= ST_WACK;
					end
				end
			end
			ST_AACK, ST_CACK, ST_WACK: begin
				if (scl_fall) begin
					if (state_r == ST_AACK && rw_r) begin
						sh_r <= rd_byte;
						sda_oe_n_r <= rd_byte[7];
						state_r <= ST_RD;
					end else begin
						sda_oe_n_r <= 1'b1;
						state_r <= (state_r == ST_AACK) ? ST_CMD : ST_WR;
					end
				end
			end
			ST_RD: begin
				if (scl_rise) begin
					cnt_r <= cnt_r + 4'h1;
				end else if (scl_fall) begin
					if (byte_done) begin
						cnt_r <= 4'h0;
						sda_oe_n_r <= 1'b1;
						ptr_r <= ptr_next;
						state_r <= ST_RACK;
					end else begin
						sh_r <= {sh_r[6:0], 1'b0};
						sda_oe_n_r <= sh_r[6];
					end
				end
			end
			ST_RACK: begin
				if (scl_rise && sda_s) begin
					state_r <= ST_IDLE;
				end else if (scl_fall) begin
					sh_r <= rd_byte;
					sda_oe_n_r <= rd_byte[7];
					state_r <= ST_RD;
				end
			end
			default: begin
				sda_oe_n_r <= 1'b1;
				state_r <= ST_IDLE;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers and alert, all registered
wire logic [15:0] od_m = {{8{ocfg_r[1]}}, {8{ocfg_r[0]}}}; // R10
wire logic [15:0] oe_n_nxt = cfg_r | (od_m & out_r); // R1 R8 R10
logic [15:0] oe_n_r;
logic [15:0] dout_r;
logic alert_oe_n_r;

always_ff @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		oe_n_r <= 16'hffff; // R9
		dout_r <= `RST_OUT;
		alert_oe_n_r <= 1'b1;
	end else begin
		oe_n_r <= oe_n_nxt;
		dout_r <= out_r;
		alert_oe_n_r <= ~|sts; // R4 R5 R22
	end
end

assign port_a_drv_o = '{dout: dout_r[7:0], oe_n: oe_n_r[7:0], drive: drv_r[15:0],
	pull_en: pen_r[7:0], pull_up: psel_r[7:0]}; // R12 R14 R15 R17
assign port_b_drv_o = '{dout: dout_r[15:8], oe_n: oe_n_r[15:8], drive: drv_r[31:16],
	pull_en: pen_r[15:8], pull_up: psel_r[15:8]};
assign sda_o = 1'b0;
assign sda_oe_n_o = sda_oe_n_r;
assign alert_o = 1'b0; // R5
assign alert_oe_n_o = alert_oe_n_r;

endmodule : i2c_gpio_expander_16bit

// [verification/gpio_exp_asserts.sv]
// port checker of the i2c gpio expander
// assumes: bound onto the expander top
`timescale 1ns/10ps
module gpio_exp_asserts
	import gpio_exp_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire port_drv_s port_a_drv_o,
	input wire port_drv_s port_b_drv_o,
	input wire logic alert_o,
	input wire logic alert_oe_n_o
);
	localparam port_drv_s DRST = '{8'hff, 8'hff, 16'hffff, 8'h00, 8'hff};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	//////////////////////////////////////////
	sequence s_idle;
		(scl_i && sda_i)[*8];
	endsequence
	sequence s_boot;
		$rose(arst_n_i);
	endsequence
	a_alert_pin_zero: assert property (alert_o == 1'b0) else $error("alert data high");
	a_sda_pin_zero: assert property (sda_o == 1'b0) else $error("sda data high");
	a_boot_inputs: assert property (s_boot |-> (&{port_a_drv_o.oe_n, port_b_drv_o.oe_n})[*8])
		else $error("line driven after reset");
	a_boot_defaults: assert property (s_boot |-> port_a_drv_o == DRST && port_b_drv_o == DRST)
		else $error("pin defaults wrong");
	a_mask_quiet: assert property (s_boot |-> alert_oe_n_o[*8]) else $error("alert after reset");
	a_ack_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i) else $error("sda pulled with scl high");
	a_idle_stable: assert property (s_idle |=> $stable(port_a_drv_o) && $stable(port_b_drv_o))
		else $error("pins moved on idle bus");
	a_idle_release: assert property (s_idle |-> sda_oe_n_o) else $error("sda held on idle bus");
endmodule : gpio_exp_asserts
bind i2c_gpio_expander_16bit gpio_exp_asserts chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .port_a_drv_o(port_a_drv_o),
	.port_b_drv_o(port_b_drv_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));

// [verification/i2c_master_model.sv]
// i2c bus master model, 200 ns bit time
// assumes: data line resolved wired-and with pull-up
`timescale 1ns/10ps
module i2c_master_model (
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	//////////////////////////////////////////
	task automatic bit_io(input logic b, output logic r);
		#25 sda_o = b;
		#100 scl_o = 1'b1;
		#37 r = sda_i;
		#38 scl_o = 1'b0;
	endtask : bit_io
	task automatic start();
		#25 sda_o = 1'b1;
		#100 scl_o = 1'b1;
		#100 sda_o = 1'b0;
		#100 scl_o = 1'b0;
	endtask : start
	task automatic stop();
		#25 sda_o = 1'b0;
		#100 scl_o = 1'b1;
		#100 sda_o = 1'b1;
		#200;
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ak);
	endtask : wbyte
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nak, r);
	endtask : rbyte
endmodule : i2c_master_model

// [verification/tb.sv]
// testbench of the i2c gpio expander
// assumes: checker bound, master model beside
`timescale 1ns/10ps
`include "gpio_exp_map.svh"
module tb
	import gpio_exp_pkg::*;
;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [7:0] pa = 8'h00;
	logic [7:0] pb = 8'h00;
	wire logic scl;
	wire logic sda_m;
	wire logic sda_l;
	logic sda_o, sda_oe_n_o, alert_o, alert_oe_n_o, ak;
	port_drv_s pa_drv, pb_drv;
	int err_count = 0;
	int checks_done = 0;
	logic [6:0] dev;
	logic [15:0] v, q;
	logic [15:0] x [9];
	logic [7:0] cm [9] = '{`CMD_OUT0, `CMD_POL0, `CMD_CFG0, `CMD_DRV0A, `CMD_DRV1A, `CMD_LAT0, `CMD_PEN0,
		`CMD_PSEL0, `CMD_MSK0};
	localparam port_drv_s DRST = '{8'hff, 8'hff, 16'hffff, 8'h00, 8'hff};
	assign sda_l = sda_m & (sda_oe_n_o | sda_o);
	initial forever #12.5 clk_i = ~clk_i;
	i2c_gpio_expander_16bit dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_l),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .slave_addr_sel_bit0_i(sel[0]), .slave_addr_sel_bit1_i(sel[1]),
		.slave_addr_sel_bit2_i(sel[2]), .port_a_line_i(pa), .port_b_line_i(pb), .port_a_drv_o(pa_drv),
		.port_b_drv_o(pb_drv), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));
	i2c_master_model m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_l));
	//////////////////////////////////////////
	task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [7:0] exp_oe(input logic [7:0] cfg, input logic [7:0] out, input logic od);
		return cfg | (od ? out : 8'h00);
	endfunction : exp_oe
	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_i);
		#2;
		m.start();
		m.wbyte({dev, 1'b0}, ak);
		chk("addr ack", ak, 1'b0);
		m.wbyte(c, ak);
		m.wbyte(d[7:0], ak);
		m.wbyte(d[15:8], ak);
		m.stop();
	endtask : wr
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge clk_i);
		#2;
		m.start();
		m.wbyte({dev, 1'b0}, ak);
		m.wbyte(c, ak);
		m.start();
		m.wbyte({dev, 1'b1}, ak);
		m.rbyte(1'b0, d[7:0]);
		m.rbyte(1'b1, d[15:8]);
		m.stop();
	endtask : rd
	task automatic setp(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk_i);
		#2;
		pa = a;
		pb = b;
	endtask : setp
	initial begin
		repeat (90000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h26f78470));
		sel = 3'($urandom);
		dev = {`ADDR_BASE, sel};
		repeat (2) @(posedge clk_i);
		#2 arst_n_i = 1'b1;
		chk("drv a", pa_drv, DRST);
		repeat (6) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			x[i] = 16'($urandom);
			wr(cm[i], x[i]);
			rd(cm[i], q);
			chk("readback", q, x[i]);
		end
		chk("oe a", pa_drv.oe_n, x[2][7:0]);
		chk("dout b", pb_drv.dout, x[0][15:8]);
		chk("drive a", pa_drv.drive, x[3]);
		chk("drive b", pb_drv.drive, x[4]);
		chk("pull en", pb_drv.pull_en, x[6][15:8]);
		chk("pull up", pa_drv.pull_up, x[7][7:0]);
		wr(`CMD_OCFG, 16'h0001);
		chk("od a", pa_drv.oe_n, exp_oe(x[2][7:0], x[0][7:0], 1'b1));
		chk("pp b", pb_drv.oe_n, exp_oe(x[2][15:8], x[0][15:8], 1'b0));
		wr(`CMD_OCFG, 16'h0002);
		chk("pp a", pa_drv.oe_n, exp_oe(x[2][7:0], x[0][7:0], 1'b0));
		chk("od b", pb_drv.oe_n, exp_oe(x[2][15:8], x[0][15:8], 1'b1));
		@(posedge clk_i);
		#2 arst_n_i = 1'b0;
		@(posedge clk_i);
		#2 arst_n_i = 1'b1;
		chk("rst b", pb_drv, DRST);
		repeat (6) @(posedge clk_i);
		rd(`CMD_MSK0, q);
		chk("mask", q, 16'hffff);
		m.start();
		m.wbyte({dev ^ 7'h01, 1'b0}, ak);
		m.stop();
		chk("foreign", ak, 1'b1);
		setp(8'($urandom), 8'($urandom));
		v = 16'($urandom);
		wr(`CMD_POL0, v);
		wr(`CMD_IN0, ~v);
		rd(`CMD_IN0, q);
		chk("input", q, {pb, pa} ^ v);
		wr(`CMD_MSK0, 16'hfffe);
		rd(`CMD_IN0, q);
		setp(pa ^ 8'h02, pb);
		repeat (20) @(posedge clk_i);
		#2;
		chk("masked", alert_oe_n_o, 1'b1);
		setp(pa ^ 8'h01, pb);
		for (int n = 0; n < 20 && alert_oe_n_o !== 1'b0; n++) #25;
		chk("alert", alert_oe_n_o, 1'b0);
		rd(`CMD_STS0, q);
		chk("status", q, 16'h0001);
		rd(`CMD_IN0, q);
		repeat (4) @(posedge clk_i);
		#2;
		chk("cleared", alert_oe_n_o, 1'b1);
		wr(`CMD_LAT0, 16'h0001);
		setp(pa ^ 8'h01, pb);
		repeat (10) @(posedge clk_i);
		setp(pa ^ 8'h01, pb);
		repeat (10) @(posedge clk_i);
		#2;
		chk("latched alert", alert_oe_n_o, 1'b0);
		rd(`CMD_IN0, q);
		chk("latched value", q, ({pb, pa} ^ v) ^ 16'h0001);
		repeat (4) @(posedge clk_i);
		#2;
		chk("latch cleared", alert_oe_n_o, 1'b1);
		print_verdict();
	end
endmodule : tb
